// ==== hdl/icir_pkg.sv ====
package icir_pkg;

	// APB access phase: one wait cycle, then the answer
	typedef enum logic [1:0] {
		ICIR_WAIT = 2'b01,
		ICIR_RESP = 2'b10
	} icir_apb_type;

	// Decoded register selects
	typedef struct packed {
		logic tx_ev_set;
		logic tx_ev_clr;
		logic tx_mask_set;
		logic tx_mask_clr;
		logic rx_ev_set;
		logic rx_ev_clr;
		logic rx_mask_set;
		logic rx_mask_clr;
		logic sum_ev;
		logic sum_mask;
	} icir_sel_type;

endpackage : icir_pkg

// ==== hdl/icir_regs.svh ====
`ifndef ICIR_REGS_SVH
`define ICIR_REGS_SVH

// Register byte offsets on the APB window
`define ICIR_TX_EV_SET   8'h90
`define ICIR_TX_EV_CLR   8'h94
`define ICIR_TX_MASK_SET 8'h98
`define ICIR_TX_MASK_CLR 8'h9c
`define ICIR_RX_EV_SET   8'ha0
`define ICIR_RX_EV_CLR   8'ha4
`define ICIR_RX_MASK_SET 8'ha8
`define ICIR_RX_MASK_CLR 8'hac
// Summary event (W1C) and summary mask (RW)
`define ICIR_SUM_EV      8'hc0
`define ICIR_SUM_MASK    8'hc4

// Summary bit positions in the summary registers
`define ICIR_SUM_TX_BIT  6
`define ICIR_SUM_RX_BIT  7

// Reset values
`define ICIR_CTX_RST     1'b0
`define ICIR_SUM_RST     1'b0
`define ICIR_RDATA_RST   32'h0000_0000

// Data bus width
`define ICIR_DATA_W      32

`endif

// ==== hdl/icir_top.sv ====
// Overview of operation
// R1: Tx request on interrupting output-last completion
// R2: Rx request on interrupting input completion
// R3: Tx event set by request edge or set-write
// R4: Rx event set by request edge or set-write
// R5: Events cleared only by one at clear
// R6: Tx event at 90h/94h, 94h reads masked
// R7: Rx event at A0h/A4h, A4h reads masked
// R8: Mask reads return raw mask contents
// R9: Tx mask set 98h, cleared 9Ch
// R10: Rx mask set A8h, cleared ACh
// R11: Tx bit n marks context n cause
// R12: Rx bit n marks context n cause
// R13: Tx event bits above 7 read zero
// R14: Rx event bits above 3 read zero
// R15: Summary interrupt needs event and mask
// R16: Summary asserted while masked event set
// R17: Software clears all before enabling interrupts
//
// Register access over APB was chosen for this implementation.
`include "icir_regs.svh"

module icir_top
	import icir_pkg::*;
#(
	parameter int TX_N = 8,                 // Transmit contexts
	parameter int RX_N = 4                  // Receive contexts
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            clk_en,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic [TX_N-1:0] tx_cmd_done,
	input  wire logic [TX_N-1:0] tx_cmd_out_last,
	input  wire logic [TX_N-1:0] tx_cmd_int_en,
	input  wire logic [RX_N-1:0] rx_cmd_done,
	input  wire logic [RX_N-1:0] rx_cmd_int_en,
	output logic                 tx_summary_event,
	output logic                 rx_summary_event,
	output logic                 irq
);

	// Event and mask storage, one bit per context
	logic [TX_N-1:0] tx_event_q;    // Transmit events
	logic [TX_N-1:0] tx_event_d;
	logic [TX_N-1:0] tx_mask_q;     // Transmit enables
	logic [TX_N-1:0] tx_mask_d;
	logic [RX_N-1:0] rx_event_q;    // Receive events
	logic [RX_N-1:0] rx_event_d;
	logic [RX_N-1:0] rx_mask_q;     // Receive enables
	logic [RX_N-1:0] rx_mask_d;

	// Request lines and their previous values
	logic [TX_N-1:0] tx_req;        // Live transmit requests
	logic [TX_N-1:0] tx_req_q;      // Last cycle's requests
	logic [TX_N-1:0] tx_rise;       // Asserting edges
	logic [RX_N-1:0] rx_req;
	logic [RX_N-1:0] rx_req_q;
	logic [RX_N-1:0] rx_rise;

	// Summary level, sticky summary event and mask
	logic [1:0]      sum_ev_q;      // [0] tx, [1] rx
	logic [1:0]      sum_ev_d;
	logic [1:0]      sum_mask_q;
	logic [1:0]      sum_lvl;       // Masked per-direction OR

	// Bus slave
	icir_apb_type    state_q;       // Access phase step
	icir_sel_type    sel;           // Address decode
	logic            mapped;        // Address hits a register
	logic            acc;           // Access phase, first cycle
	logic            wr_go;         // Write takes effect now
	logic [31:0]     rdata_d;       // Read mux output
	logic [31:0]     prdata_q;
	logic            pslverr_q;

	// Decode one address into register selects
	function automatic icir_sel_type dec(input logic [7:0] a);
		icir_sel_type s;
		s             = '0;
		s.tx_ev_set   = (a == `ICIR_TX_EV_SET);
		s.tx_ev_clr   = (a == `ICIR_TX_EV_CLR);
		s.tx_mask_set = (a == `ICIR_TX_MASK_SET);
		s.tx_mask_clr = (a == `ICIR_TX_MASK_CLR);
		s.rx_ev_set   = (a == `ICIR_RX_EV_SET);
		s.rx_ev_clr   = (a == `ICIR_RX_EV_CLR);
		s.rx_mask_set = (a == `ICIR_RX_MASK_SET);
		s.rx_mask_clr = (a == `ICIR_RX_MASK_CLR);
		s.sum_ev      = (a == `ICIR_SUM_EV);
		s.sum_mask    = (a == `ICIR_SUM_MASK);
		return s;
	endfunction : dec

	// Set/clear update; a set in the same cycle beats the clear
	function automatic logic [31:0] sc_upd(
		input logic [31:0] cur,
		input logic [31:0] set,
		input logic [31:0] clr
	);
		return (cur & ~clr) | set;
	endfunction : sc_upd

	assign sel    = dec(paddr);
	assign mapped = |sel;
	assign acc    = psel & penable & (state_q == ICIR_WAIT);
	assign wr_go  = psel & penable & pwrite & (state_q == ICIR_RESP);

	// Request conditions from the context engines
	assign tx_req  = tx_cmd_done & tx_cmd_out_last & tx_cmd_int_en; // [R1]
	assign rx_req  = rx_cmd_done & rx_cmd_int_en; // [R2]
	assign tx_rise = tx_req & ~tx_req_q;
	assign rx_rise = rx_req & ~rx_req_q;

	// Previous request levels for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_req_q <= '0;
			rx_req_q <= '0;
		end else if (clk_en) begin
			tx_req_q <= tx_req;
			rx_req_q <= rx_req;
		end
	end

	// Next event and mask values
	always_comb begin
		logic [31:0] ws;
		logic [31:0] wc;
		ws         = '0;
		wc         = '0;
		// Transmit events: bit n belongs to context n
		ws = (wr_go && sel.tx_ev_set) ? pwdata : '0;
		wc = (wr_go && sel.tx_ev_clr) ? pwdata : '0;
		tx_event_d = TX_N'(sc_upd(32'(tx_event_q), // [R3] [R5] [R11]
			32'(tx_rise) | ws, wc));
		// Receive events
		ws = (wr_go && sel.rx_ev_set) ? pwdata : '0;
		wc = (wr_go && sel.rx_ev_clr) ? pwdata : '0;
		rx_event_d = RX_N'(sc_upd(32'(rx_event_q), // [R4] [R5] [R12]
			32'(rx_rise) | ws, wc));
		// Transmit mask
		ws = (wr_go && sel.tx_mask_set) ? pwdata : '0;
		wc = (wr_go && sel.tx_mask_clr) ? pwdata : '0;
		tx_mask_d = TX_N'(sc_upd(32'(tx_mask_q), ws, wc)); // [R9]
		// Receive mask
		ws = (wr_go && sel.rx_mask_set) ? pwdata : '0;
		wc = (wr_go && sel.rx_mask_clr) ? pwdata : '0;
		rx_mask_d = RX_N'(sc_upd(32'(rx_mask_q), ws, wc)); // [R10]
	end

	// Event registers; unknown in silicon, zero here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_event_q <= {TX_N{`ICIR_CTX_RST}};
			rx_event_q <= {RX_N{`ICIR_CTX_RST}};
		end else if (clk_en) begin
			tx_event_q <= tx_event_d;
			rx_event_q <= rx_event_d;
		end
	end

	// Mask registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_mask_q <= {TX_N{`ICIR_CTX_RST}};
			rx_mask_q <= {RX_N{`ICIR_CTX_RST}};
		end else if (clk_en) begin
			tx_mask_q <= tx_mask_d;
			rx_mask_q <= rx_mask_d;
		end
	end

	// Masked per-direction summary levels
	assign sum_lvl[0] = |(tx_event_q & tx_mask_q); // [R16]
	assign sum_lvl[1] = |(rx_event_q & rx_mask_q); // [R16]

	// Summary outputs registered to keep them glitch free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_summary_event <= `ICIR_SUM_RST;
			rx_summary_event <= `ICIR_SUM_RST;
		end else if (clk_en) begin
			tx_summary_event <= sum_lvl[0]; // [R16]
			rx_summary_event <= sum_lvl[1]; // [R16]
		end
	end

	// Sticky summary event: the registered summary output beats a W1C clear,
	// so a clear while a context is still pending is refused
	always_comb begin
		sum_ev_d = sum_ev_q;
		if (wr_go && sel.sum_ev) begin
			sum_ev_d[0] = sum_ev_q[0] & ~pwdata[`ICIR_SUM_TX_BIT];
			sum_ev_d[1] = sum_ev_q[1] & ~pwdata[`ICIR_SUM_RX_BIT];
		end
		sum_ev_d = sum_ev_d | {rx_summary_event, tx_summary_event};
	end

	// Summary event and mask registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sum_ev_q   <= {2{`ICIR_SUM_RST}};
			sum_mask_q <= {2{`ICIR_SUM_RST}};
		end else if (clk_en) begin
			sum_ev_q <= sum_ev_d;
			if (wr_go && sel.sum_mask) begin
				sum_mask_q[0] <= pwdata[`ICIR_SUM_TX_BIT];
				sum_mask_q[1] <= pwdata[`ICIR_SUM_RX_BIT];
			end
		end
	end

	// Interrupt only when event and mask are both one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= `ICIR_SUM_RST;
		end else if (clk_en) begin
			irq <= |(sum_ev_q & sum_mask_q); // [R15]
		end
	end

	// Read mux; narrow fields zero extended
	always_comb begin
		rdata_d = '0;
		unique case (1'b1)
			sel.tx_ev_set: begin
				rdata_d = 32'(tx_event_q); // [R13]
			end
			sel.tx_ev_clr: begin
				rdata_d = 32'(tx_event_q & tx_mask_q); // [R6] [R13]
			end
			sel.tx_mask_set, sel.tx_mask_clr: begin
				rdata_d = 32'(tx_mask_q); // [R8]
			end
			sel.rx_ev_set: begin
				rdata_d = 32'(rx_event_q); // [R14]
			end
			sel.rx_ev_clr: begin
				rdata_d = 32'(rx_event_q & rx_mask_q); // [R7] [R14]
			end
			sel.rx_mask_set, sel.rx_mask_clr: begin
				rdata_d = 32'(rx_mask_q); // [R8]
			end
			sel.sum_ev: begin
				rdata_d[`ICIR_SUM_TX_BIT] = sum_ev_q[0];
				rdata_d[`ICIR_SUM_RX_BIT] = sum_ev_q[1];
			end
			sel.sum_mask: begin
				rdata_d[`ICIR_SUM_TX_BIT] = sum_mask_q[0];
				rdata_d[`ICIR_SUM_RX_BIT] = sum_mask_q[1];
			end
			default: begin
				rdata_d = '0;
			end
		endcase
	end

	// Access step: one wait cycle lets read data come from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ICIR_WAIT;
		end else if (clk_en) begin
			unique case (state_q)
				ICIR_WAIT: begin
					if (acc) begin
						state_q <= ICIR_RESP;
					end
				end
				ICIR_RESP: begin
					state_q <= ICIR_WAIT;
				end
				default: begin
					state_q <= ICIR_WAIT;
				end
			endcase
		end
	end

	// Read data and error captured in the wait cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= `ICIR_RDATA_RST;
			pslverr_q <= 1'b0;
		end else if (clk_en && acc) begin
			prdata_q  <= pwrite ? `ICIR_RDATA_RST : rdata_d;
			pslverr_q <= ~mapped;
		end
	end

	assign pready  = (state_q == ICIR_RESP);
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q & pready;

	// Checks
	logic wr_tx_clr;  // Helper: write at transmit clear
	logic wr_rx_clr;
	logic any_wr;
	assign wr_tx_clr = wr_go & sel.tx_ev_clr;
	assign wr_rx_clr = wr_go & sel.rx_ev_clr;
	assign any_wr    = wr_go & mapped;

	a_tx_edge_sets: assert property (@(posedge pclk) // [R3]
		disable iff (!presetn)
		(clk_en && |tx_rise) |=>
		((tx_event_q & $past(tx_rise)) == $past(tx_rise)))
		else $error("tx event not set by request edge");

	a_rx_edge_sets: assert property (@(posedge pclk) // [R4]
		disable iff (!presetn)
		(clk_en && |rx_rise) |=>
		((rx_event_q & $past(rx_rise)) == $past(rx_rise)))
		else $error("rx event not set by request edge");

	a_tx_no_spurious: assert property (@(posedge pclk) // [R1]
		disable iff (!presetn)
		(clk_en && !any_wr) |=>
		((tx_event_q & ~$past(tx_event_q) & ~$past(tx_rise)) == '0))
		else $error("tx event set without cause");

	a_tx_clr_only: assert property (@(posedge pclk) // [R5]
		disable iff (!presetn)
		(!wr_tx_clr) |=>
		(($past(tx_event_q) & ~tx_event_q) == '0))
		else $error("tx event lost without clear write");

	a_rx_clr_only: assert property (@(posedge pclk) // [R5]
		disable iff (!presetn)
		(!wr_rx_clr) |=>
		(($past(rx_event_q) & ~rx_event_q) == '0))
		else $error("rx event lost without clear write");

	a_tx_clr_read: assert property (@(posedge pclk) // [R6]
		disable iff (!presetn)
		(clk_en && acc && !pwrite && sel.tx_ev_clr) |=>
		(pready && prdata == 32'($past(tx_event_q) & $past(tx_mask_q))))
		else $error("tx clear read not masked events");

	a_rx_clr_read: assert property (@(posedge pclk) // [R7]
		disable iff (!presetn)
		(clk_en && acc && !pwrite && sel.rx_ev_clr) |=>
		(pready && prdata == 32'($past(rx_event_q) & $past(rx_mask_q))))
		else $error("rx clear read not masked events");

	a_mask_read: assert property (@(posedge pclk) // [R8]
		disable iff (!presetn)
		(clk_en && acc && !pwrite && sel.tx_mask_clr) |=>
		(prdata == 32'($past(tx_mask_q))))
		else $error("tx mask read altered");

	a_rsvd_zero: assert property (@(posedge pclk) // [R13] [R14]
		disable iff (!presetn)
		(pready && (sel.tx_ev_set || sel.rx_ev_set)) |->
		(prdata[31:RX_N] == '0 || sel.tx_ev_set) &&
		(prdata[31:TX_N] == '0))
		else $error("reserved event bits not zero");

	a_sum_follows: assert property (@(posedge pclk) // [R16]
		disable iff (!presetn)
		(clk_en && sum_lvl[0]) |=> tx_summary_event)
		else $error("tx summary missing");

	a_irq_gate: assert property (@(posedge pclk) // [R15]
		disable iff (!presetn)
		(clk_en && !(|(sum_ev_q & sum_mask_q))) |=> !irq)
		else $error("irq without event and mask");

endmodule : icir_top

// ==== verif/iso_context_interrupt_regs_tb.sv ====
`include "icir_regs.svh"

module iso_context_interrupt_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk, presetn, clk_en;  // Clock, reset, run enable
	logic        psel, penable, pwrite;  // APB controls
	logic [7:0]  paddr;                  // Byte address
	logic [31:0] pwdata, prdata;         // APB data
	logic        pready, pslverr;        // APB answer
	logic [7:0]  tx_cmd_done, tx_cmd_out_last, tx_cmd_int_en;
	logic [3:0]  rx_cmd_done, rx_cmd_int_en;
	logic        tx_summary_event, rx_summary_event, irq;
	logic [31:0] rd;                     // Last read data
	logic        er;                     // Last error flag
	int          num_errors, tests_run;  // Report counters

	icir_top #(.TX_N(8), .RX_N(4)) dut_u (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_cmd_done(tx_cmd_done),
		.tx_cmd_out_last(tx_cmd_out_last), .tx_cmd_int_en(tx_cmd_int_en),
		.rx_cmd_done(rx_cmd_done), .rx_cmd_int_en(rx_cmd_int_en),
		.tx_summary_event(tx_summary_event),
		.rx_summary_event(rx_summary_event), .irq(irq)
	);

	// Free running 200 MHz clock
	initial begin
		pclk = 1'h0;
		forever #2.5 pclk = ~pclk;
	end

	// Verdict and end of run
	task tally_and_finish;
		$display("errors %0d comparisons %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	// One compare for every 32-bit result
	task check(input string what, input logic [31:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask : check

	// APB transfer; request held until the edge that sees pready
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Answer, data and error all taken at the rising edge
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		// Bounded wait: a silent slave ends the run
		if (pready !== 1'h1) begin
			num_errors++;
			tally_and_finish();
		end else begin
			rd = prdata;
			er = pslverr;
			psel    <= 1'h0;
			penable <= 1'h0;
		end
	endtask : apb

	// Read and compare data
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'h0, 32'h0);
		check("read data", exp, rd);
	endtask : rd_chk

	// Reset held for eight cycles
	task do_reset;
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
	endtask : do_reset

	// All mapped words zero after reset; unmapped refused
	task reset_scan;
		for (int a = 'h90; a <= 'hc4; a += 4) begin
			if (a > 'hac && a < 'hc0)
				continue;
			rd_chk(8'(a), 32'h0);
			check("slave error", 32'h0, {31'h0, er});
		end
		apb(8'h88, 1'h1, 32'hffff_ffff);
		check("unmapped error", 32'h1, {31'h0, er});
		rd_chk(`ICIR_TX_EV_SET, 32'h0);
		check("outputs", 32'h0, {29'h0, tx_summary_event,
			rx_summary_event, irq});
	endtask : reset_scan

	// Software set, clear and mask for one direction
	task regs_dir(input logic [7:0] b, input logic [31:0] wm, input logic x);
		apb(b, 1'h1, 32'hffff_ffff);
		rd_chk(b, wm);
		rd_chk(b + 8'h4, 32'h0);
		apb(b + 8'h8, 1'h1, 32'h0000_00a5);
		rd_chk(b + 8'h8, wm & 32'h0000_00a5);
		rd_chk(b + 8'hc, wm & 32'h0000_00a5);
		rd_chk(b + 8'h4, wm & 32'h0000_00a5);
		check("summary", 32'h1, {31'h0, x ? rx_summary_event :
			tx_summary_event});
		apb(b + 8'h4, 1'h1, 32'h0);
		rd_chk(b, wm);
		apb(b + 8'h4, 1'h1, 32'h0000_0005);
		rd_chk(b, wm & ~32'h0000_0005);
		apb(b + 8'hc, 1'h1, 32'hffff_ffff);
		rd_chk(b + 8'h8, 32'h0);
		check("summary", 32'h0, {31'h0, x ? rx_summary_event :
			tx_summary_event});
		apb(b + 8'h4, 1'h1, 32'hffff_ffff);
		rd_chk(b, 32'h0);
	endtask : regs_dir

	// One-cycle command completion on context n
	task pulse(input logic x, input int n, input logic last, ien);
		@(posedge pclk);
		if (x) begin
			rx_cmd_done[n]   <= 1'h1;
			rx_cmd_int_en[n] <= ien;
		end else begin
			tx_cmd_done[n]     <= 1'h1;
			tx_cmd_out_last[n] <= last;
			tx_cmd_int_en[n]   <= ien;
		end
		@(posedge pclk);
		{tx_cmd_done, tx_cmd_out_last, tx_cmd_int_en} <= 24'h0;
		{rx_cmd_done, rx_cmd_int_en} <= 8'h0;
	endtask : pulse

	// Hardware requests per context, qualified and edge only
	task ctx_events;
		for (int n = 0; n < 8; n++) begin
			pulse(1'h0, n, 1'h0, 1'h1);
			pulse(1'h0, n, 1'h1, 1'h0);
			rd_chk(`ICIR_TX_EV_SET, 32'h0);
			pulse(1'h0, n, 1'h1, 1'h1);
			rd_chk(`ICIR_TX_EV_SET, 32'h1 << n);
			apb(`ICIR_TX_EV_CLR, 1'h1, 32'hffff_ffff);
		end
		for (int n = 0; n < 4; n++) begin
			pulse(1'h1, n, 1'h0, 1'h0);
			rd_chk(`ICIR_RX_EV_SET, 32'h0);
			pulse(1'h1, n, 1'h0, 1'h1);
			rd_chk(`ICIR_RX_EV_SET, 32'h1 << n);
			apb(`ICIR_RX_EV_CLR, 1'h1, 32'hffff_ffff);
		end
		// Frozen clock enable: a request seen only while frozen is lost
		@(posedge pclk);
		clk_en <= 1'h0;
		pulse(1'h0, 0, 1'h1, 1'h1);
		clk_en <= 1'h1;
		rd_chk(`ICIR_TX_EV_SET, 32'h0);
		// A request held high must not set again after a clear
		@(posedge pclk);
		{tx_cmd_done[3], tx_cmd_out_last[3], tx_cmd_int_en[3]} <= 3'h7;
		rd_chk(`ICIR_TX_EV_SET, 32'h0000_0008);
		apb(`ICIR_TX_EV_CLR, 1'h1, 32'h0000_0008);
		rd_chk(`ICIR_TX_EV_SET, 32'h0);
		@(posedge pclk);
		{tx_cmd_done, tx_cmd_out_last, tx_cmd_int_en} <= 24'h0;
	endtask : ctx_events

	// Summary events and interrupt line gated by summary mask
	task irq_path;
		// Start clean: earlier scenarios left sticky summary bits
		apb(`ICIR_TX_EV_CLR, 1'h1, 32'hffff_ffff);
		apb(`ICIR_RX_EV_CLR, 1'h1, 32'hffff_ffff);
		apb(`ICIR_SUM_EV, 1'h1, 32'hffff_ffff);
		rd_chk(`ICIR_SUM_EV, 32'h0);
		apb(`ICIR_TX_MASK_SET, 1'h1, 32'h0000_0001);
		apb(`ICIR_TX_EV_SET, 1'h1, 32'h0000_0001);
		rd_chk(`ICIR_SUM_EV, 32'h0000_0040);
		check("irq masked", 32'h0, {31'h0, irq});
		apb(`ICIR_SUM_MASK, 1'h1, 32'h0000_0040);
		rd_chk(`ICIR_SUM_MASK, 32'h0000_0040);
		check("irq raised", 32'h1, {31'h0, irq});
		apb(`ICIR_TX_EV_CLR, 1'h1, 32'h0000_0001);
		apb(`ICIR_SUM_EV, 1'h1, 32'h0000_0040);
		rd_chk(`ICIR_SUM_EV, 32'h0);
		check("irq cleared", 32'h0, {31'h0, irq});
		// Receive side: event without summary mask stays quiet
		apb(`ICIR_RX_MASK_SET, 1'h1, 32'h0000_0001);
		apb(`ICIR_RX_EV_SET, 1'h1, 32'h0000_0001);
		rd_chk(`ICIR_SUM_EV, 32'h0000_0080);
		check("irq rx masked", 32'h0, {31'h0, irq});
		apb(`ICIR_RX_EV_CLR, 1'h1, 32'hffff_ffff);
		apb(`ICIR_SUM_EV, 1'h1, 32'hffff_ffff);
	endtask : irq_path

	// Main sequence
	initial begin
		num_errors = 0;
		tests_run  = 0;
		presetn    = 1'h0;
		clk_en     = 1'h1;
		{psel, penable, pwrite} = 3'h0;
		paddr  = 8'h0;
		pwdata = 32'h0;
		{tx_cmd_done, tx_cmd_out_last, tx_cmd_int_en} = 24'h0;
		{rx_cmd_done, rx_cmd_int_en} = 8'h0;
		do_reset();
		reset_scan();
		regs_dir(`ICIR_TX_EV_SET, 32'h0000_00ff, 1'h0);
		regs_dir(`ICIR_RX_EV_SET, 32'h0000_000f, 1'h1);
		ctx_events();
		irq_path();
		// Mid-run reset with state loaded
		apb(`ICIR_TX_EV_SET, 1'h1, 32'hffff_ffff);
		do_reset();
		reset_scan();
		tally_and_finish();
	end

endmodule : iso_context_interrupt_regs_tb
